// File: src/i2c_master_pkg.sv
/*
 Constants, types and register map of the I2C master sequencer.
 Assumes a 125 MHz system clock and a standard-mode (100 kHz) bus.
*/
// Notes on behaviour
// - Ack value bit: set sends NACK, clear ACK
// - Ack trigger drives ack slot with value
// - Hardware clears ack trigger when sequence ends
// - Receive trigger reads one byte, clears after eighth
// - Stop trigger makes Stop, cleared when done
// - Restart trigger makes Repeated Start, cleared when done
// - Start trigger makes Start, cleared when done
`default_nettype none

package i2c_master_pkg;

	// Register byte offsets
	localparam logic [3:0] CONTROL_OFS = 4'h0;
	localparam logic [3:0] RXDATA_OFS  = 4'h4;
	localparam logic [3:0] STATUS_OFS  = 4'h8;

	// Control field positions
	localparam int START_BIT   = 0;
	localparam int RESTART_BIT = 1;
	localparam int STOP_BIT    = 2;
	localparam int RECV_BIT    = 3;
	localparam int ACKSEQ_BIT  = 4;
	localparam int ACKVAL_BIT  = 5;
	localparam logic [15:0] CONTROL_RESET = 16'h0000;

	// Bus timing: one quarter of a 100 kHz bit period
	localparam int CLK_NS         = 8;
	localparam int QUARTER_NS     = 2500;
	localparam int QUARTER_CYCLES = (QUARTER_NS + CLK_NS - 1) / CLK_NS;

	// Receive buffer shape
	localparam int FIFO_WIDTH = 8;
	localparam int FIFO_DEPTH = 8;

	// Sequencer states, one-hot
	typedef enum logic [5:0] {
		ST_IDLE    = 6'h01,
		ST_START   = 6'h02,
		ST_RESTART = 6'h04,
		ST_STOP    = 6'h08,
		ST_RECV    = 6'h10,
		ST_ACK     = 6'h20
	} state_type;

	// Open-drain pull-down request for both lines
	typedef struct packed {
		logic scl_low;
		logic sda_low;
	} line_type;

endpackage

`default_nettype wire

// File: src/i2c_master_sequence_control.sv
/*
 Receive FIFO and the I2C master sequencer with its Wishbone slave.
 Assumes external pull-ups on both lines and a classic Wishbone master.
*/
`timescale 1ns/1ps
`default_nettype none

// Synchronous FIFO with valid/ready on both sides
module rx_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input  wire logic             clk_i,       // System clock
	input  wire logic             rst_i,       // Synchronous reset
	input  wire logic [WIDTH-1:0] in_data_i,   // Write data
	input  wire logic             in_valid_i,  // Write request
	output logic                  in_ready_o,  // Room available
	output logic      [WIDTH-1:0] out_data_o,  // Head word
	output logic                  out_valid_o, // Head valid
	input  wire logic             out_ready_i  // Head consumed
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wr_ptr_reg;
	logic [AW:0]      rd_ptr_reg;
	wire              push;
	wire              pop;

	// Full when pointers differ only in the wrap bit
	assign in_ready_o  = !((wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
		(wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]));
	assign out_valid_o = (wr_ptr_reg != rd_ptr_reg);
	assign out_data_o  = mem[rd_ptr_reg[AW-1:0]];
	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_valid_o && out_ready_i;

	// Storage write
	always_ff @(posedge clk_i) begin
		if (push) begin
			mem[wr_ptr_reg[AW-1:0]] <= in_data_i;
		end
	end

	// Pointer update
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
		end else begin
			wr_ptr_reg <= wr_ptr_reg + (AW+1)'(push);
			rd_ptr_reg <= rd_ptr_reg + (AW+1)'(pop);
		end
	end
endmodule

// Master sequencer: Start, Repeated Start, Stop, byte receive, acknowledge
module i2c_master_sequence_control
	import i2c_master_pkg::*;
(
	input  wire logic        clk_i,      // System clock, 125 MHz
	input  wire logic        rst_i,      // Synchronous reset, active high
	input  wire logic [3:0]  wb_adr_i,   // Byte address
	input  wire logic [31:0] wb_dat_i,   // Write data
	input  wire logic [3:0]  wb_sel_i,   // Byte lanes
	input  wire logic        wb_we_i,    // Write enable
	input  wire logic        wb_cyc_i,   // Cycle
	input  wire logic        wb_stb_i,   // Strobe
	output logic      [31:0] wb_dat_o,   // Read data
	output logic             wb_ack_o,   // Acknowledge
	input  wire logic        scl_i,      // Clock line level
	output logic             scl_o,      // Clock line drive value
	output logic             scl_oe_o,   // Clock line pulled low
	input  wire logic        sda_i,      // Data line level
	output logic             sda_o,      // Data line drive value
	output logic             sda_oe_o    // Data line pulled low
);
	localparam int TW = $clog2(QUARTER_CYCLES);

	// Pin levels for a state and quarter; 1 means pull low
	function automatic line_type drive(state_type s, logic [1:0] q,
		logic nack);
		line_type l;
		l = '0;
		case (s)
			ST_START: begin
				l.sda_low = (q >= 2'd1);
				l.scl_low = (q == 2'd2);
			end
			ST_RESTART: begin
				l.sda_low = (q >= 2'd2);
				l.scl_low = (q == 2'd0) || (q == 2'd3);
			end
			ST_STOP: begin
				l.sda_low = (q <= 2'd1);
				l.scl_low = (q == 2'd0);
			end
			ST_RECV: begin
				l.scl_low = (q == 2'd0) || (q == 2'd3);
			end
			ST_ACK: begin
				l.sda_low = !nack;
				l.scl_low = (q == 2'd0) || (q == 2'd3);
			end
			default: l = '0;
		endcase
		return l;
	endfunction

	state_type        st_reg;
	state_type        st_next;
	logic [4:0]       trig_reg;
	logic             ackval_reg;
	logic [TW-1:0]    tmr_reg;
	logic [1:0]       q_reg;
	logic [2:0]       bit_reg;
	logic [7:0]       shift_reg;
	line_type         line_reg;
	logic [1:0]       scl_sync_reg;
	logic [1:0]       sda_sync_reg;
	logic             ack_reg;
	logic [31:0]      dat_reg;
	logic             fifo_ready;
	logic             fifo_valid;
	logic [7:0]       fifo_data;

	wire              wb_req    = wb_cyc_i && wb_stb_i && !ack_reg;
	wire              wr_ctrl   = wb_req && wb_we_i && wb_sel_i[0] &&
		(wb_adr_i == CONTROL_OFS);
	wire              rd_rx     = wb_req && !wb_we_i &&
		(wb_adr_i == RXDATA_OFS);
	wire              idle      = (st_reg == ST_IDLE);
	wire              tick      = (tmr_reg == TW'(QUARTER_CYCLES - 1));
	wire              last_q    = (st_reg == ST_START || st_reg == ST_STOP)
		? (q_reg == 2'd2) : (q_reg == 2'd3);
	wire              seq_end   = !idle && tick && last_q &&
		((st_reg != ST_RECV) || (bit_reg == 3'd7));
	wire              recv_done = seq_end && (st_reg == ST_RECV);
	wire              sample    = tick && (q_reg == 2'd2) &&
		(st_reg == ST_RECV);
	wire [7:0]        rx_byte   = {shift_reg[6:0], sda_sync_reg[1]};
	wire [15:0]       ctrl_view = {10'h000, ackval_reg, trig_reg};
	// Empty buffer reads zero instead of a stale or unwritten word
	wire [7:0]        rx_view   = fifo_valid ? fifo_data : 8'h00;
	// Status: busy, byte ready, full, synced data and clock levels
	wire [31:0]       status    = {27'h0, scl_sync_reg[1],
		sda_sync_reg[1], !fifo_ready, fifo_valid, !idle};

	// Launch order when idle; receive waits for buffer room
	always_comb begin
		st_next = st_reg;
		if (idle) begin
			if (trig_reg[START_BIT]) begin
				st_next = ST_START;
			end else if (trig_reg[RESTART_BIT]) begin
				st_next = ST_RESTART;
			end else if (trig_reg[STOP_BIT]) begin
				st_next = ST_STOP;
			end else if (trig_reg[RECV_BIT] && fifo_ready) begin
				st_next = ST_RECV;
			end else if (trig_reg[ACKSEQ_BIT]) begin
				st_next = ST_ACK;
			end
		end else if (seq_end) begin
			st_next = ST_IDLE;
		end
	end

	// Two-flop synchronisers on the bus lines
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			scl_sync_reg <= 2'b11;
			sda_sync_reg <= 2'b11;
		end else begin
			scl_sync_reg <= {scl_sync_reg[0], scl_i};
			sda_sync_reg <= {sda_sync_reg[0], sda_i};
		end
	end

	// Control register; triggers accepted only while idle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			trig_reg   <= CONTROL_RESET[4:0];
			ackval_reg <= CONTROL_RESET[ACKVAL_BIT];
		end else begin
			if (wr_ctrl) begin
				ackval_reg <= wb_dat_i[ACKVAL_BIT];
			end
			if (seq_end) begin
				trig_reg <= 5'h00;
			end else if (wr_ctrl && idle && st_next == ST_IDLE) begin
				trig_reg <= wb_dat_i[4:0];
			end
		end
	end

	// Sequencer state, quarter timer and bit count
	always_ff @(posedge clk_i) begin
		if (rst_i || idle) begin
			st_reg  <= rst_i ? ST_IDLE : st_next;
			tmr_reg <= '0;
			q_reg   <= 2'd0;
			bit_reg <= 3'd0;
		end else begin
			st_reg  <= st_next;
			tmr_reg <= tick ? '0 : tmr_reg + TW'(1);
			q_reg   <= tick ? q_reg + 2'd1 : q_reg;
			bit_reg <= (tick && q_reg == 2'd3) ? bit_reg + 3'd1 : bit_reg;
		end
	end

	// Shift in data at the end of each high phase
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			shift_reg <= 8'h00;
		end else if (sample) begin
			shift_reg <= rx_byte;
		end
	end

	// Pin drivers; lines hold their last level between sequences
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			line_reg <= '0;
		end else if (!idle) begin
			line_reg <= drive(st_reg, q_reg, ackval_reg);
		end
	end

	// Wishbone slave answer one cycle after request
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
			dat_reg <= 32'h00000000;
		end else begin
			ack_reg <= wb_req;
			case (wb_adr_i)
				CONTROL_OFS: dat_reg <= {16'h0000, ctrl_view};
				RXDATA_OFS:  dat_reg <= {24'h000000, rx_view};
				STATUS_OFS:  dat_reg <= status;
				default:     dat_reg <= 32'h00000000;
			endcase
		end
	end

	rx_fifo #(
		.WIDTH (FIFO_WIDTH),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk_i       (clk_i),
		.rst_i       (rst_i),
		.in_data_i   (shift_reg),
		.in_valid_i  (recv_done),
		.in_ready_o  (fifo_ready),
		.out_data_o  (fifo_data),
		.out_valid_o (fifo_valid),
		.out_ready_i (rd_rx)
	);

	// Output pins straight from flip-flops; scl_o and sda_o tied low
	assign wb_ack_o = ack_reg;
	assign wb_dat_o = dat_reg;
	assign scl_oe_o = line_reg.scl_low;
	assign sda_oe_o = line_reg.sda_low;
	assign scl_o    = 1'b0;
	assign sda_o    = 1'b0;

	// Checks on bus sequences and register behaviour
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	a_ack_nack_level: assert property (
		$past(st_reg == ST_ACK && ackval_reg) |-> !sda_oe_o)
		else $error("NACK slot pulled data low");
	a_ack_drive_low: assert property (
		$past(st_reg == ST_ACK && !ackval_reg) |-> sda_oe_o)
		else $error("ACK slot left data released");
	a_ack_trig_clear: assert property (
		$fell(st_reg == ST_ACK) |-> !trig_reg[ACKSEQ_BIT])
		else $error("Ack trigger not cleared at end");
	a_recv_eight_bits: assert property (
		$fell(st_reg == ST_RECV) |-> $past(bit_reg) == 3'd7 &&
		!trig_reg[RECV_BIT])
		else $error("Receive ended off the eighth bit");
	a_stop_release: assert property (
		$past(st_reg == ST_STOP && q_reg == 2'd2) |->
		!sda_oe_o && !scl_oe_o)
		else $error("Stop did not release both lines");
	a_restart_fall: assert property (
		$past(st_reg == ST_RESTART && q_reg == 2'd2) |->
		sda_oe_o && !scl_oe_o)
		else $error("Repeated Start data not low under high clock");
	a_start_fall: assert property (
		$past(st_reg == ST_START && q_reg == 2'd1) |->
		sda_oe_o && !scl_oe_o)
		else $error("Start data not low under high clock");
	a_one_sequence: assert property (
		!idle |-> ##1 (st_reg == $past(st_reg) || idle))
		else $error("Sequence switched without going idle");
	a_wb_ack_pulse: assert property (
		wb_ack_o |=> !wb_ack_o)
		else $error("Bus acknowledge held over two cycles");

	c_start_done: cover property ($fell(st_reg == ST_START));
	c_recv_done: cover property (recv_done);
	c_nack_sent: cover property ($fell(st_reg == ST_ACK) && ackval_reg);
	c_fifo_full: cover property (!fifo_ready);
endmodule

`default_nettype wire

// File: verification/i2c_slave_model.sv
/*
 Behavioural I2C slave facing the master sequencer.
 Assumes pull-ups on both lines and resolved line levels at its inputs.
*/
`timescale 1ns/1ps
`default_nettype none

module i2c_slave_model (
	input  wire logic       scl_i,      // Clock line level
	input  wire logic       sda_i,      // Data line level
	input  wire logic [7:0] tx_byte_i,  // Byte sent during master receive
	output logic            sda_low_o,  // Pull data line low
	output int              starts_o,   // Start conditions seen
	output int              stops_o,    // Stop conditions seen
	output logic            last_bit_o  // Data level at last clock rise
);
	int cnt = 8;

	// Start or Repeated Start restarts the bit counter
	initial begin
		starts_o = 0;
		stops_o = 0;
	end
	always @(negedge sda_i) if (scl_i === 1'b1) begin
		cnt = -1;
		starts_o++;
	end
	always @(posedge sda_i) if (scl_i === 1'b1) stops_o++;

	// Data changes only while the clock is low
	always @(negedge scl_i) cnt++;
	always @(posedge scl_i) last_bit_o = sda_i;

	// Byte goes out MSB first; line released outside the byte
	assign sda_low_o = cnt >= 0 && cnt < 8 && !tx_byte_i[7 - cnt];
endmodule

`default_nettype wire

// File: verification/tb.sv
/*
 Self-checking bench for the I2C master sequencer.
 Assumes the slave model file is compiled first and pull-ups on both lines.
*/
`timescale 1ns/1ps
`default_nettype none

module tb;
	import i2c_master_pkg::*;
	logic        clk_i;
	logic        rst_i;
	logic [3:0]  wb_adr;
	logic [31:0] wb_dat;
	logic [3:0]  wb_sel;
	logic        wb_we;
	logic        wb_cyc;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o;
	logic        scl_oe_o;
	logic        sda_oe_o;
	logic        scl_drv;
	logic        sda_drv;
	logic        slv_low;
	int          starts;
	int          stops;
	logic        last_bit;
	int          n_errors = 0;
	int          checked = 0;
	wire         scl_line = ~scl_oe_o;
	wire         sda_line = ~(sda_oe_o | slv_low);

	i2c_master_sequence_control i2c_master_sequence_control_i (
		.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr), .wb_dat_i(wb_dat),
		.wb_sel_i(wb_sel), .wb_we_i(wb_we), .wb_cyc_i(wb_cyc),
		.wb_stb_i(wb_cyc), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.scl_i(scl_line), .scl_o(scl_drv), .scl_oe_o(scl_oe_o),
		.sda_i(sda_line), .sda_o(sda_drv), .sda_oe_o(sda_oe_o));
	i2c_slave_model i2c_slave_model_i (
		.scl_i(scl_line), .sda_i(sda_line), .tx_byte_i(8'hA5),
		.sda_low_o(slv_low), .starts_o(starts), .stops_o(stops),
		.last_bit_o(last_bit));

	// Clock at 125 MHz
	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end

	task automatic wrap_up;
		$display("mismatches %0d comparisons %0d", n_errors, checked);
		if (n_errors == 0 && checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s exp %h got %h", what, exp, got);
		end
	endtask

	// One classic cycle; entered and left just after a rising edge
	task automatic wb(input logic [3:0] a, input logic w,
		input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		wb_adr <= a;
		wb_we <= w;
		wb_dat <= d;
		wb_sel <= 4'hF;
		wb_cyc <= 1'b1;
		@(posedge clk_i);
		while (wb_ack_o !== 1'b1) begin
			if (++n > 20) begin
				n_errors++;
				wrap_up();
			end
			@(posedge clk_i);
		end
		q = wb_dat_o;
		wb_cyc <= 1'b0;
		wb_we <= 1'b0;
		wb_sel <= 4'h0;
		@(posedge clk_i);
	endtask

	// Trigger must read set, then clear by itself within a bound
	task automatic wait_clear(input int b);
		logic [31:0] q;
		int n;
		n = 0;
		wb(CONTROL_OFS, 1'b0, 32'h0, q);
		chk("trigger pending", 32'h1, {31'h0, q[b]});
		while (q[b] !== 1'b0) begin
			if (++n > 6000) begin
				n_errors++;
				wrap_up();
			end
			wb(CONTROL_OFS, 1'b0, 32'h0, q);
		end
	endtask

	task automatic t_reset;
		logic [31:0] q;
		wb(CONTROL_OFS, 1'b0, 32'h0, q);
		chk("control reset", {16'h0, CONTROL_RESET}, q);
		wb(4'hC, 1'b1, 32'hFF, q);
		wb(4'hC, 1'b0, 32'h0, q);
		chk("unmapped read", 32'h0, q);
		wb(STATUS_OFS, 1'b0, 32'h0, q);
		chk("idle status", 32'h18, q);
		chk("drive values", 32'h0, {30'h0, scl_drv, sda_drv});
	endtask

	task automatic t_start;
		int s;
		logic [31:0] q;
		s = starts;
		wb(CONTROL_OFS, 1'b1, 32'h01, q);
		wait_clear(START_BIT);
		chk("start seen", s + 1, starts);
		chk("lines low", 32'h3, {30'h0, scl_oe_o, sda_oe_o});
	endtask

	// Receive one byte; a start written meanwhile must be dropped
	task automatic t_receive;
		int s;
		logic [31:0] q;
		s = starts;
		wb(CONTROL_OFS, 1'b1, 32'h08, q);
		wb(CONTROL_OFS, 1'b1, 32'h01, q);
		wait_clear(RECV_BIT);
		wb(CONTROL_OFS, 1'b0, 32'h0, q);
		chk("busy write dropped", 32'h0, q);
		chk("no extra start", s, starts);
		wb(STATUS_OFS, 1'b0, 32'h0, q);
		chk("byte ready status", 32'h0A, q);
		wb(RXDATA_OFS, 1'b0, 32'h0, q);
		chk("rx byte", 32'hA5, q);
		wb(RXDATA_OFS, 1'b0, 32'h0, q);
		chk("rx empty", 32'h0, q);
	endtask

	// Acknowledge slot carries the value bit: 0 ACK, 1 NACK
	task automatic t_ack;
		logic [31:0] q;
		for (int v = 0; v < 2; v++) begin
			wb(CONTROL_OFS, 1'b1, 32'h10 | (v << ACKVAL_BIT), q);
			wait_clear(ACKSEQ_BIT);
			chk("ack slot level", v, {31'h0, last_bit});
			wb(CONTROL_OFS, 1'b0, 32'h0, q);
			chk("ack value kept", v << ACKVAL_BIT, q);
		end
	endtask

	task automatic t_restart_stop;
		int s;
		int p;
		logic [31:0] q;
		s = starts;
		p = stops;
		wb(CONTROL_OFS, 1'b1, 32'h02, q);
		wait_clear(RESTART_BIT);
		chk("restart seen", s + 1, starts);
		wb(CONTROL_OFS, 1'b1, 32'h04, q);
		wait_clear(STOP_BIT);
		chk("stop seen", p + 1, stops);
		chk("lines free", 32'h0, {30'h0, scl_oe_o, sda_oe_o});
	endtask

	// Reset for two cycles, then the scenarios in bus order
	initial begin
		rst_i = 1'b1;
		wb_adr = 4'h0;
		wb_dat = 32'h0;
		wb_sel = 4'h0;
		wb_we = 1'b0;
		wb_cyc = 1'b0;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		t_reset();
		t_start();
		t_receive();
		t_ack();
		t_restart_stop();
		wrap_up();
	end
endmodule

`default_nettype wire
